// ==== core/sep_pkg.sv ====
package sep_pkg;
   localparam int SEP_ADDR_W = 8;
   // arbitrary type code; both ends take it from here
   localparam logic [3:0] SEP_DEV_TYPE = 4'h6;
   localparam logic [7:0] SEP_ERASED = 8'hff;
   localparam logic [7:0] SEP_TOP_1K = 8'h7f;
   localparam logic [7:0] SEP_TOP_2K = 8'hff;
   localparam int SEP_MEM_DEPTH = 256;
   // internal write time in cycles, kept short on purpose
   localparam int SEP_WRITE_CYC = 200;
   // master bit quarter period: 25 ns * 50 = 1.25 us
   localparam int SEP_QUARTER_CYC = 50;
   localparam int SEP_MAX_BURST = 16;
endpackage

// ==== core/sep_if.sv ====
`timescale 1ns/1ps
interface sep_if;
   logic scl;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_s_o;
   logic sda_s_oe_n;
   wire sda = (!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o) ? 1'b0 : 1'b1;
   modport slave(input scl, input sda, output sda_s_o, output sda_s_oe_n);
   modport master(output scl, input sda, output sda_m_o, output sda_m_oe_n);
endinterface

// ==== core/sep_slave.sv ====
`timescale 1ns/1ps
module sep_slave
   import sep_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // bus
   sep_if.slave bus,
   // straps
   input wire logic write_protect_input,
   input wire logic chip_select_bit_2,
   input wire logic chip_select_bit_1,
   input wire logic chip_select_bit_0,
   input wire logic five_pin_package_variant,
   input wire logic size_2k,
   // status
   output logic busy
);
   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_RXB = 6'h02, S_ACK = 6'h04,
      S_TXB = 6'h08, S_MACK = 6'h10, S_WAIT = 6'h20
   } sep_state_t;
   typedef enum logic [1:0] {P_SEL = 2'h0, P_ADDR = 2'h1, P_DATA = 2'h2} sep_phase_t;
   typedef struct packed {
      logic [1:0] scl_s, sda_s;
      logic [1:0] wp_s, five_s, big_s;
      logic [5:0] cs_s;
      logic scl_p, sda_p;
      sep_state_t fsm;
      sep_phase_t ph;
      logic [3:0] bit_n;
      logic [7:0] sh;
      logic [7:0] addr;
      logic [7:0] wbuf_a;
      logic [7:0] wbuf_d;
      logic [4:0] wcnt;
      logic wpend;
      logic nack;
      logic sda_o;
      logic [15:0] busy_cnt;
   } sep_s_t;
   sep_s_t q, d;
   logic [7:0] mem [SEP_MEM_DEPTH];
   logic [7:0] wb_a [SEP_MAX_BURST];
   logic [7:0] wb_d [SEP_MAX_BURST];
   logic do_write;

   function automatic logic [7:0] next_addr(input logic [7:0] a, input logic big,
                                            input logic five);
      logic [7:0] top;
      top = big ? SEP_TOP_2K : SEP_TOP_1K;
      if (five) next_addr = a + 8'h01;
      else if (a >= top) next_addr = 8'h00;
      else next_addr = a + 8'h01;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic scl, sda, rise, fall, start, stop;
   logic wp, five, big;
   logic [2:0] chip_pins;
   logic [7:0] sel_byte;
   assign scl = q.scl_s[1];
   assign sda = q.sda_s[1];
   // straps are pins as well, so they pass the same two flops as the bus
   assign wp = q.wp_s[1];
   assign five = q.five_s[1];
   assign big = q.big_s[1];
   assign chip_pins = q.cs_s[5:3];
   assign rise = scl && !q.scl_p;
   assign fall = !scl && q.scl_p;
   assign start = scl && q.scl_p && q.sda_p && !sda;
   assign stop = scl && q.scl_p && !q.sda_p && sda;
   assign sel_byte = {q.sh[6:0], sda};

   always_comb begin
      d = q;
      do_write = 1'b0;
      d.scl_s = {q.scl_s[0], bus.scl};
      d.sda_s = {q.sda_s[0], bus.sda};
      d.wp_s = {q.wp_s[0], write_protect_input};
      d.five_s = {q.five_s[0], five_pin_package_variant};
      d.big_s = {q.big_s[0], size_2k};
      d.cs_s = {q.cs_s[2:0], chip_select_bit_2, chip_select_bit_1, chip_select_bit_0};
      d.scl_p = scl;
      d.sda_p = sda;
      if (q.busy_cnt != 16'h0000) begin
         d.busy_cnt = q.busy_cnt - 16'h0001;
         d.fsm = S_IDLE;
         d.sda_o = 1'b1;
      end else if (start) begin
         d.fsm = S_RXB;
         d.ph = P_SEL;
         d.bit_n = 4'h0;
         d.sda_o = 1'b1;
         d.wcnt = 5'h00;
         d.wpend = 1'b0;
      end else if (stop) begin
         // the clock rise of the tenth slot is taken as bit one before the stop shows
         if (q.wpend && q.fsm == S_RXB && q.bit_n <= 4'h1) begin
            do_write = 1'b1;
            d.busy_cnt = 16'(SEP_WRITE_CYC);
         end
         d.fsm = S_IDLE;
         d.sda_o = 1'b1;
         d.wpend = 1'b0;
      end else begin
         case (q.fsm)
            S_IDLE: d.sda_o = 1'b1;
            S_RXB: if (rise) begin
               d.sh = {q.sh[6:0], sda};
               d.bit_n = q.bit_n + 4'h1;
               if (q.bit_n == 4'h7) begin
                  d.fsm = S_WAIT;
                  d.wpend = 1'b0;
                  case (q.ph)
                     P_SEL: begin
                        if (sel_byte[7:4] == SEP_DEV_TYPE &&
                            sel_byte[3:1] == (five ? 3'h0 : chip_pins))
                           d.nack = 1'b0;
                        else d.fsm = S_IDLE;
                     end
                     P_ADDR: begin
                        d.addr = sel_byte;
                        d.nack = 1'b0;
                     end
                     default: d.nack = wp;
                  endcase
               end
            end
            S_WAIT: if (fall) begin
               d.sda_o = q.nack;
               d.fsm = S_ACK;
            end
            S_ACK: if (fall) begin
               d.bit_n = 4'h0;
               d.sda_o = 1'b1;
               if (q.nack) d.fsm = S_IDLE;
               else if (q.ph == P_SEL && q.sh[0]) begin
                  d.fsm = S_TXB;
                  d.sh = mem[q.addr];
                  d.sda_o = mem[q.addr][7];
               end else begin
                  d.fsm = S_RXB;
                  if (q.ph == P_DATA) begin
                     d.wpend = 1'b1;
                     d.addr = next_addr(q.addr, big, five);
                     if (q.wcnt != 5'(SEP_MAX_BURST)) d.wcnt = q.wcnt + 5'h01;
                  end
                  d.ph = (q.ph == P_SEL) ? P_ADDR : P_DATA;
               end
            end
            S_TXB: if (fall) begin
               d.bit_n = q.bit_n + 4'h1;
               d.sh = {q.sh[6:0], 1'b1};
               if (q.bit_n == 4'h7) begin
                  d.sda_o = 1'b1;
                  d.fsm = S_MACK;
                  d.addr = next_addr(q.addr, big, five);
               end else d.sda_o = q.sh[6];
            end
            S_MACK: if (rise) begin
               if (sda) d.fsm = S_IDLE;
               else begin
                  d.fsm = S_WAIT;
                  d.nack = 1'b0;
                  d.sh = 8'h01;
                  d.ph = P_SEL;
               end
            end
            default: d.fsm = S_IDLE;
         endcase
         // sequential continuation: no device ack slot, load next byte on fall
         if (q.fsm == S_WAIT && q.ph == P_SEL && q.sh == 8'h01 && fall && q.nack == 1'b0 &&
             q.bit_n == 4'h8) begin
            d.fsm = S_TXB;
            d.bit_n = 4'h0;
            d.sh = mem[q.addr];
            d.sda_o = mem[q.addr][7];
         end
      end
   end

   // burst capture, written into the array only by the write cycle
   always_ff @(posedge mclk) begin
      if (q.fsm == S_ACK && fall && q.ph == P_DATA && !q.nack && !start && !stop &&
          q.busy_cnt == 16'h0000 && q.wcnt != 5'(SEP_MAX_BURST)) begin
         wb_a[q.wcnt[3:0]] <= q.addr;
         wb_d[q.wcnt[3:0]] <= q.sh;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < SEP_MEM_DEPTH; i++) mem[i] <= SEP_ERASED;
      end else if (do_write) begin
         for (int i = 0; i < SEP_MAX_BURST; i++)
            if (5'(i) < q.wcnt) mem[wb_a[i]] <= wb_d[i];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '{scl_s: 2'h3, sda_s: 2'h3, wp_s: 2'h0, five_s: 2'h0, big_s: 2'h0, cs_s: 6'h00,
                scl_p: 1'b1, sda_p: 1'b1, fsm: S_IDLE,
                ph: P_SEL, bit_n: 4'h0, sh: 8'h00, addr: 8'h00, wbuf_a: 8'h00,
                wbuf_d: 8'h00, wcnt: 5'h00, wpend: 1'b0, nack: 1'b1, sda_o: 1'b1,
                busy_cnt: 16'h0000};
      end else begin
         q <= d;
      end
   end

   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe_n = q.sda_o;
   assign busy = (q.busy_cnt != 16'h0000);
endmodule

// ==== core/sep_master.sv ====
`timescale 1ns/1ps
module sep_master
   import sep_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // bus
   sep_if.master bus,
   // request
   input wire logic req_valid,
   input wire logic req_random,
   input wire logic [7:0] req_addr,
   input wire logic [2:0] req_chip,
   input wire logic [4:0] req_len,
   output logic req_ready,
   // answer
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic done,
   output logic nak_err
);
   typedef enum logic [3:0] {
      M_IDLE = 4'h1, M_START = 4'h2, M_BITS = 4'h4, M_STOP = 4'h8
   } sep_mst_t;
   typedef struct packed {
      logic [1:0] sda_s;
      sep_mst_t fsm;
      logic [1:0] qtr;
      logic [7:0] qcnt;
      logic [3:0] bit_n;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [1:0] phase;
      logic rnd;
      logic [7:0] addr;
      logic [2:0] chip;
      logic [4:0] left;
      logic scl;
      logic sda_o;
      logic [7:0] rd_data;
      logic rd_valid;
      logic done;
      logic nak;
   } sep_m_t;
   sep_m_t q, d;
   logic tick, sda;
   assign sda = q.sda_s[1];
   assign tick = (q.qcnt == 8'(SEP_QUARTER_CYC - 1));

   ////////////////////////////////////////////////////////////////////////
   // phase 0: select, 1: address, 2: read select, 3: data
   always_comb begin
      d = q;
      d.sda_s = {q.sda_s[0], bus.sda};
      d.rd_valid = 1'b0;
      d.done = 1'b0;
      d.qcnt = tick ? 8'h00 : q.qcnt + 8'h01;
      case (q.fsm)
         M_IDLE: begin
            d.qcnt = 8'h00;
            if (req_valid) begin
               d.rnd = req_random;
               d.addr = req_addr;
               d.chip = req_chip;
               d.left = (req_len == 5'h00) ? 5'h01 : req_len;
               d.nak = 1'b0;
               d.phase = req_random ? 2'h0 : 2'h2;
               d.fsm = M_START;
               d.qtr = 2'h0;
            end
         end
         M_START: if (tick) begin
            d.qtr = q.qtr + 2'h1;
            case (q.qtr)
               2'h0: begin
                  d.sda_o = 1'b1;
                  d.scl = 1'b1;
               end
               2'h1: d.sda_o = 1'b0;
               2'h2: d.scl = 1'b0;
               default: begin
                  d.fsm = M_BITS;
                  d.bit_n = 4'h0;
                  d.qtr = 2'h0;
                  d.tx = (q.phase == 2'h0) ? {SEP_DEV_TYPE, q.chip, 1'b0} :
                         {SEP_DEV_TYPE, q.chip, 1'b1};
                  d.sda_o = (q.phase == 2'h0) ? SEP_DEV_TYPE[3] : SEP_DEV_TYPE[3];
               end
            endcase
         end
         M_BITS: if (tick) begin
            d.qtr = q.qtr + 2'h1;
            case (q.qtr)
               2'h0: d.scl = 1'b1;
               2'h1: if (q.bit_n < 4'h8) d.rx = {q.rx[6:0], sda};
                     else if (q.phase != 2'h3 && sda) d.nak = 1'b1;
               2'h2: d.scl = 1'b0;
               default: begin
                  d.qtr = 2'h0;
                  d.bit_n = q.bit_n + 4'h1;
                  if (q.bit_n == 4'h7) begin
                     if (q.phase == 2'h3) begin
                        d.rd_data = q.rx;
                        d.rd_valid = 1'b1;
                        d.left = q.left - 5'h01;
                        d.sda_o = (q.left == 5'h01);
                     end else d.sda_o = 1'b1;
                  end else if (q.bit_n == 4'h8) begin
                     d.bit_n = 4'h0;
                     if (q.nak) begin
                        d.fsm = M_STOP;
                        d.sda_o = 1'b0;
                     end else case (q.phase)
                        2'h0: begin
                           d.phase = 2'h1;
                           d.tx = q.addr;
                           d.sda_o = q.addr[7];
                        end
                        2'h1: begin
                           d.phase = 2'h2;
                           d.fsm = M_START;
                           d.sda_o = 1'b1;
                        end
                        2'h2: begin
                           d.phase = 2'h3;
                           d.sda_o = 1'b1;
                        end
                        default: if (q.left == 5'h00) begin
                           d.fsm = M_STOP;
                           d.sda_o = 1'b0;
                        end else d.sda_o = 1'b1;
                     endcase
                  end else if (q.phase != 2'h3) begin
                     d.tx = {q.tx[6:0], 1'b0};
                     d.sda_o = q.tx[6];
                  end
               end
            endcase
         end
         M_STOP: if (tick) begin
            d.qtr = q.qtr + 2'h1;
            case (q.qtr)
               2'h0: d.scl = 1'b1;
               2'h1: d.sda_o = 1'b1;
               2'h2: ;
               default: begin
                  d.fsm = M_IDLE;
                  d.done = 1'b1;
               end
            endcase
         end
         default: d.fsm = M_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '{sda_s: 2'h3, fsm: M_IDLE, qtr: 2'h0, qcnt: 8'h00, bit_n: 4'h0,
                tx: 8'h00, rx: 8'h00, phase: 2'h0, rnd: 1'b0, addr: 8'h00,
                chip: 3'h0, left: 5'h00, scl: 1'b1, sda_o: 1'b1, rd_data: 8'h00,
                rd_valid: 1'b0, done: 1'b0, nak: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign bus.scl = q.scl;
   assign bus.sda_m_o = 1'b0;
   assign bus.sda_m_oe_n = q.sda_o;
   assign req_ready = (q.fsm == M_IDLE);
   assign rd_data = q.rd_data;
   assign rd_valid = q.rd_valid;
   assign done = q.done;
   assign nak_err = q.nak;
endmodule

// ==== testbench/sep_sva.sv ====
`timescale 1ns/1ps
module sep_sva
   import sep_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // link
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_o,
   input wire logic sda_m_oe_n,
   input wire logic sda_s_o,
   input wire logic sda_s_oe_n,
   // status
   input wire logic busy
);
   // erased bytes never pull the line, so only an ack slot plus sync lag holds it low
   localparam int LOW_MAX = 4 * SEP_QUARTER_CYC + 8;

   logic [15:0] low_run_q;

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (rst || sda_s_oe_n) begin
         low_run_q <= 16'h0000;
      end else begin
         low_run_q <= low_run_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   chk_ack_slot_free: assert property (scl && !sda_m_oe_n |-> sda_s_oe_n)
      else $error("slave drives while master pulls the line");
   chk_busy_quiet: assert property (busy |-> sda_s_oe_n)
      else $error("slave drives during write cycle");
   chk_no_write_cycle: assert property (!busy)
      else $error("write cycle started by a read");
   chk_stable_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe_n))
      else $error("slave output moved while clock high");
   chk_drive_onset: assert property ($fell(sda_s_oe_n) |-> !scl)
      else $error("slave started driving with clock high");
   chk_stop_standby: assert property (scl && $rose(sda) |-> sda_s_oe_n [*8])
      else $error("slave active after stop");
   chk_start_quiet: assert property (scl && $fell(sda) |=> sda_s_oe_n [*8])
      else $error("slave drives right after start");
   chk_low_run: assert property (low_run_q <= LOW_MAX)
      else $error("slave held line low too long");
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import sep_pkg::*;

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

   logic mclk, rst, wp, cs2, cs1, cs0, five, s2k, busy;
   logic req_valid, req_random, req_ready, rd_valid, done, nak_err;
   logic [7:0] req_addr;
   logic [2:0] req_chip;
   logic [4:0] req_len;
   logic [7:0] rd_data;
   int err_count;
   int samples_checked;

   ////////////////////////////////////////////////////////////////////////////////
   sep_if bus();

   sep_slave sep_slave_i(.mclk(mclk), .rst(rst), .bus(bus), .write_protect_input(wp),
      .chip_select_bit_2(cs2), .chip_select_bit_1(cs1), .chip_select_bit_0(cs0),
      .five_pin_package_variant(five), .size_2k(s2k), .busy(busy));

   sep_master sep_master_i(.mclk(mclk), .rst(rst), .bus(bus), .req_valid(req_valid),
      .req_random(req_random), .req_addr(req_addr), .req_chip(req_chip),
      .req_len(req_len), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .done(done), .nak_err(nak_err));

   sep_sva sep_sva_i(.mclk(mclk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
      .sda_m_o(bus.sda_m_o), .sda_m_oe_n(bus.sda_m_oe_n), .sda_s_o(bus.sda_s_o),
      .sda_s_oe_n(bus.sda_s_oe_n), .busy(busy));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // one whole transfer; every byte must come back erased
   task automatic run(input logic rnd, input logic [7:0] addr, input logic [2:0] chip,
         input logic [4:0] len, input int exp_n, input logic exp_nak,
         input logic [7:0] exp_addr);
      int n;
      int t;
      n = 0;
      t = 0;
      req_random <= rnd;
      req_addr <= addr;
      req_chip <= chip;
      req_len <= len;
      req_valid <= 1'b1;
      @(posedge mclk);
      while (req_ready !== 1'b1) @(posedge mclk);
      req_valid <= 1'b0;
      while (done !== 1'b1 && t < 20000) begin
         @(posedge mclk);
         t++;
         if (rd_valid === 1'b1) begin
            n++;
            `CHK("rd_data", SEP_ERASED, rd_data)
         end
      end
      `CHK("done", 1'b1, done)
      `CHK("byte_count", exp_n, n)
      `CHK("addr_counter", exp_addr, sep_slave_i.q.addr)
      `CHK("nak_err", exp_nak, nak_err)
      `CHK("busy", 1'b0, busy)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   initial begin
      err_count = 0;
      samples_checked = 0;
      rst = 1'b1;
      wp = 1'b0;
      cs2 = 1'b1;
      cs1 = 1'b0;
      cs0 = 1'b1;
      five = 1'b0;
      s2k = 1'b1;
      req_valid = 1'b0;
      req_random = 1'b0;
      req_addr = 8'h00;
      req_chip = 3'h0;
      req_len = 5'h00;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      run(1'b1, 8'h10, 3'h5, 5'h01, 1, 1'b0, 8'h11);
      run(1'b0, 8'h00, 3'h5, 5'h01, 1, 1'b0, 8'h12);
      run(1'b1, 8'hfe, 3'h5, 5'h04, 4, 1'b0, 8'h02);
      run(1'b1, 8'h10, 3'h2, 5'h01, 0, 1'b1, 8'h02);
      wp <= 1'b1;
      run(1'b0, 8'h00, 3'h5, 5'h02, 2, 1'b0, 8'h04);
      wp <= 1'b0;
      s2k <= 1'b0;
      run(1'b1, 8'h7e, 3'h5, 5'h03, 3, 1'b0, 8'h01);
      five <= 1'b1;
      run(1'b1, 8'h20, 3'h0, 5'h01, 1, 1'b0, 8'h21);
      run(1'b0, 8'h00, 3'h0, 5'h02, 2, 1'b0, 8'h23);
      summarize;
   end

   // the full sequence needs about two thirds of this span
   initial begin
      repeat (90000) @(posedge mclk);
      err_count++;
      $display("[FAIL] watchdog expected done seen hang");
      summarize;
   end
endmodule
